// file: include/atps_pkg.sv
// package: register map, field layout, structs and timing constants of the converter config block
package atps_pkg;

	// ****************************************
	// register map (word index, byte address = index * 4)
	// ****************************************
	localparam int ADDR_W = 16;
	localparam logic [13:0] IDX_PIN_LOW = 14'h2040;
	localparam logic [13:0] IDX_PIN_MID = 14'h2041;
	localparam logic [13:0] IDX_PIN_HIGH = 14'h2042;
	localparam logic [13:0] IDX_TIMING = 14'h2055;
	localparam logic [13:0] IDX_REF = 14'h2056;
	localparam logic [13:0] IDX_CLK = 14'h2057;
	localparam logic [13:0] IDX_STATUS = 14'h2058;

	// reset values and writable-bit masks (reserved bits read zero)
	localparam logic [7:0] RST_PIN = 8'h00;
	localparam logic [7:0] RST_TIMING = 8'h7f;
	localparam logic [7:0] RST_REF = 8'h00;
	localparam logic [7:0] RST_CLK = 8'h00;
	localparam logic [7:0] MASK_PIN = 8'hff;
	localparam logic [7:0] MASK_TIMING = 8'h7f;
	localparam logic [7:0] MASK_REF = 8'h1f;
	localparam logic [7:0] MASK_CLK = 8'hf3;

	// ****************************************
	// field positions
	// ****************************************
	localparam int REF_SRC_BIT = 4;
	localparam int REF_LVL_BIT = 3;
	localparam int REF_CH_LSB = 1;
	localparam int OFS_MODE_BIT = 0;
	localparam int WNUM_LSB = 2;
	localparam int COMP_BIAS_BIT = 0;
	localparam int AMP_BIAS_BIT = 1;
	localparam int FILTER_BIT = 7;
	localparam int GAP_BIT = 6;
	localparam int SDEL_LSB = 4;
	localparam int CKDIV_LSB = 0;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_CCLK_BIT = 1;

	// ****************************************
	// timing constants
	// ****************************************
	localparam int PLL_HZ = 48_000_000;
	localparam int CONV_HZ_0 = 3_000_000;
	localparam int CONV_HZ_1 = 2_000_000;
	localparam int CONV_HZ_2 = 1_500_000;
	localparam int CONV_HZ_3 = 1_000_000;
	localparam logic [5:0] HALF_0 = 6'(PLL_HZ / (2 * CONV_HZ_0));
	localparam logic [5:0] HALF_1 = 6'(PLL_HZ / (2 * CONV_HZ_1));
	localparam logic [5:0] HALF_2 = 6'(PLL_HZ / (2 * CONV_HZ_2));
	localparam logic [5:0] HALF_3 = 6'(PLL_HZ / (2 * CONV_HZ_3));
	localparam logic [5:0] WAIT_BASE = 6'h03;
	localparam logic [5:0] SDEL_0 = 6'h00;
	localparam logic [5:0] SDEL_1 = 6'h02;
	localparam logic [5:0] SDEL_2 = 6'h04;
	localparam logic [5:0] SDEL_3 = 6'h08;

	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic filter_en;
		logic comp_bias_hi;
		logic amp_bias_hi;
		logic ref_source_sel;
		logic ref_level_sel;
		logic [1:0] internal_ref_channel;
		logic offset_cancel_open;
	} atps_analog_cfg_s;

	typedef struct packed {
		logic [4:0] post_sample_wait_count;
		logic sample_compare_gap;
		logic [1:0] sample_delay_sel;
		logic [1:0] conv_clock_div_sel;
	} atps_timing_s;

endpackage

// file: design/atps_clk_div.sv
// conversion clock divider working off the pll clock tick
`timescale 1ns/1ps
module atps_clk_div (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic pll_tick,
	input wire logic [1:0] div_sel,
	output logic conv_clk,
	output logic conv_tick
);
	logic [5:0] half_cnt_reg;
	logic [5:0] half_lim;
	logic conv_clk_reg;
	logic conv_tick_reg;

	// half-period length per select code
	always_comb begin
		case (div_sel)
			2'h0: half_lim = atps_pkg::HALF_0;
			2'h1: half_lim = atps_pkg::HALF_1;
			2'h2: half_lim = atps_pkg::HALF_2;
			default: half_lim = atps_pkg::HALF_3;
		endcase
	end

	// >= so a smaller ratio chosen mid-period cannot run the counter away
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			half_cnt_reg <= 6'h00;
			conv_clk_reg <= 1'b0;
			conv_tick_reg <= 1'b0;
		end else begin
			conv_tick_reg <= 1'b0;
			if (pll_tick) begin
				if (half_cnt_reg + 6'h01 >= half_lim) begin
					half_cnt_reg <= 6'h00;
					conv_clk_reg <= ~conv_clk_reg;
					conv_tick_reg <= ~conv_clk_reg; // pulse on rising edge
				end else begin
					half_cnt_reg <= half_cnt_reg + 6'h01;
				end
			end
		end
	end

	assign conv_clk = conv_clk_reg;
	assign conv_tick = conv_tick_reg;
endmodule

// file: design/atps_seq.sv
// post-sample wait counter that releases the compare phase
`timescale 1ns/1ps
module atps_seq (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic conv_tick,
	input wire logic sample_done,
	input wire atps_pkg::atps_timing_s timing,
	output logic compare_start,
	output logic busy
);
	typedef enum logic [1:0] {
		ATPS_IDLE = 2'b01,
		ATPS_WAIT = 2'b10
	} atps_seq_state_e;

	atps_seq_state_e state_reg;
	logic [5:0] cnt_reg;
	logic [5:0] sdel;
	logic [5:0] total;
	logic start_reg;

	// sample delay lookup and total wait in conversion clocks
	always_comb begin
		case (timing.sample_delay_sel)
			2'h0: sdel = atps_pkg::SDEL_0;
			2'h1: sdel = atps_pkg::SDEL_1;
			2'h2: sdel = atps_pkg::SDEL_2;
			default: sdel = atps_pkg::SDEL_3;
		endcase
		total = atps_pkg::WAIT_BASE + {1'b0, timing.post_sample_wait_count} + sdel
			+ {5'h00, timing.sample_compare_gap};
	end

	// a sample end while already waiting is ignored
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			state_reg <= ATPS_IDLE;
			cnt_reg <= 6'h00;
			start_reg <= 1'b0;
		end else begin
			start_reg <= 1'b0;
			case (state_reg)
				ATPS_IDLE: begin
					if (sample_done) begin
						cnt_reg <= total;
						state_reg <= ATPS_WAIT;
					end
				end
				ATPS_WAIT: begin
					if (conv_tick) begin
						if (cnt_reg == 6'h01) begin
							start_reg <= 1'b1;
							state_reg <= ATPS_IDLE;
						end else begin
							cnt_reg <= cnt_reg - 6'h01;
						end
					end
				end
				default: state_reg <= ATPS_IDLE;
			endcase
		end
	end

	assign compare_start = start_reg;
	assign busy = (state_reg == ATPS_WAIT);
endmodule

// file: design/atps_top.sv
// converter timing, reference and pin-select configuration block with axi4-lite registers
//
// Summary of operation
// - reference source bit 4 picks supply (0) or internal precision reference (1).
// - reference level bit 3 picks lower (0) or higher (1) internal level.
// - bits 2..1 choose one of four rising levels for the internal channel.
// - bit 0 low cancels comparator offset after sampling; high opens all switches.
// - wait three plus post-sample wait count conversion clocks before converting.
// - bias bit 0 drives comparator, bit 1 amplifier; one means doubled current.
// - clock control bit 7 inserts input resistor filter; default off.
// - gap bit 6 adds one conversion clock between sampling and compare.
// - bits 5..4 give sample delay of 0, 2, 4 or 8 conversion clocks.
// - bits 1..0 select conversion clock of 3, 2, 1.5 or 1 MHz.
// - first pin-select register bit n enables analog channel n, 0..7.
// - second and third registers enable channels 8..15 and 16..23.
// - a selected pin is forced to input direction automatically.
// - conversion clock divides down from the 48 MHz pll clock.
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module atps_top #(
	parameter int PIN_COUNT = 24
) (
	input wire logic sys_clk,
	input wire logic resetn,
	// axi4-lite slave
	input wire logic [atps_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [atps_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// pll clock and converter core
	input wire logic pll_tick,
	input wire logic sample_done,
	output atps_pkg::atps_analog_cfg_s analog_cfg,
	output atps_pkg::atps_timing_s timing_cfg,
	output logic conv_clk,
	output logic conv_tick,
	output logic compare_start,
	// pin multiplexer
	output logic [PIN_COUNT-1:0] pin_analog_en,
	output logic [PIN_COUNT-1:0] pin_force_input
);

	// ****************************************
	// storage
	// ****************************************

	// pin selects kept as an indexed array of byte registers
	logic [7:0] pin_sel_reg [3];
	logic [7:0] timing_reg;
	logic [7:0] ref_reg;
	logic [7:0] clk_reg;

	// axi slave state
	logic aw_got_reg;
	logic w_got_reg;
	logic [13:0] aw_idx_reg;
	logic [7:0] w_byte_reg;
	logic w_en_reg;
	logic awready_reg;
	logic wready_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic arready_reg;
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;
	logic [31:0] rdata_next;
	logic [1:0] rresp_next;
	logic wr_hit;
	logic do_write;

	// config carriers and helper outputs
	atps_pkg::atps_analog_cfg_s analog_cfg_reg;
	atps_pkg::atps_timing_s timing_cfg_reg;
	logic [PIN_COUNT-1:0] pin_en_reg;
	logic [PIN_COUNT-1:0] pin_in_reg;
	logic seq_busy;
	logic seq_start;
	logic div_clk;
	logic div_tick;

	// ****************************************
	// axi write channel
	// ****************************************

	// address and data are taken in either order, then committed together
	assign do_write = aw_got_reg && w_got_reg && !bvalid_reg;

	// write address acceptance
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			aw_got_reg <= 1'b0;
			aw_idx_reg <= 14'h0000;
			awready_reg <= 1'b0;
		end else begin
			if (s_axi_awvalid && awready_reg) begin
				aw_got_reg <= 1'b1;
				aw_idx_reg <= s_axi_awaddr[atps_pkg::ADDR_W-1:2];
				awready_reg <= 1'b0;
			end else if (do_write) begin
				aw_got_reg <= 1'b0;
			end else if (!aw_got_reg && !bvalid_reg) begin
				awready_reg <= 1'b1; // ready returns only after the response is taken
			end
		end
	end

	// write data acceptance; only the low byte lane carries register data
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			w_got_reg <= 1'b0;
			w_byte_reg <= 8'h00;
			w_en_reg <= 1'b0;
			wready_reg <= 1'b0;
		end else begin
			if (s_axi_wvalid && wready_reg) begin
				w_got_reg <= 1'b1;
				w_byte_reg <= s_axi_wdata[7:0];
				w_en_reg <= s_axi_wstrb[0];
				wready_reg <= 1'b0;
			end else if (do_write) begin
				w_got_reg <= 1'b0;
			end else if (!w_got_reg && !bvalid_reg) begin
				wready_reg <= 1'b1;
			end
		end
	end

	// decode of the latched write address
	always_comb begin
		case (aw_idx_reg)
			atps_pkg::IDX_PIN_LOW,
			atps_pkg::IDX_PIN_MID,
			atps_pkg::IDX_PIN_HIGH,
			atps_pkg::IDX_TIMING,
			atps_pkg::IDX_REF,
			atps_pkg::IDX_CLK,
			atps_pkg::IDX_STATUS: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	// write response; unmapped addresses answer slverr
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			bvalid_reg <= 1'b0;
			bresp_reg <= atps_pkg::RESP_OKAY;
		end else begin
			if (do_write) begin
				bvalid_reg <= 1'b1;
				bresp_reg <= wr_hit ? atps_pkg::RESP_OKAY : atps_pkg::RESP_SLVERR;
			end else if (bvalid_reg && s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	// ****************************************
	// register file
	// ****************************************

	// byte registers
	// reserved bits are masked so they always read back as zero
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			timing_reg <= atps_pkg::RST_TIMING;
			ref_reg <= atps_pkg::RST_REF;
			clk_reg <= atps_pkg::RST_CLK;
		end else if (do_write && w_en_reg) begin
			case (aw_idx_reg)
				atps_pkg::IDX_TIMING: timing_reg <= w_byte_reg & atps_pkg::MASK_TIMING;
				atps_pkg::IDX_REF: ref_reg <= w_byte_reg & atps_pkg::MASK_REF;
				atps_pkg::IDX_CLK: clk_reg <= w_byte_reg & atps_pkg::MASK_CLK;
				default: ;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			pin_sel_reg[0] <= atps_pkg::RST_PIN;
			pin_sel_reg[1] <= atps_pkg::RST_PIN;
			pin_sel_reg[2] <= atps_pkg::RST_PIN;
		end else if (do_write && w_en_reg) begin
			case (aw_idx_reg)
				atps_pkg::IDX_PIN_LOW: pin_sel_reg[0] <= w_byte_reg;
				atps_pkg::IDX_PIN_MID: pin_sel_reg[1] <= w_byte_reg;
				atps_pkg::IDX_PIN_HIGH: pin_sel_reg[2] <= w_byte_reg;
				default: ;
			endcase
		end
	end

	// ****************************************
	// axi read channel
	// ****************************************

	// read mux; status shows the live sequencer and divider state
	always_comb begin
		rdata_next = 32'h0000_0000;
		rresp_next = atps_pkg::RESP_OKAY;
		case (s_axi_araddr[atps_pkg::ADDR_W-1:2])
			atps_pkg::IDX_PIN_LOW: rdata_next[7:0] = pin_sel_reg[0];
			atps_pkg::IDX_PIN_MID: rdata_next[7:0] = pin_sel_reg[1];
			atps_pkg::IDX_PIN_HIGH: rdata_next[7:0] = pin_sel_reg[2];
			atps_pkg::IDX_TIMING: rdata_next[7:0] = timing_reg;
			atps_pkg::IDX_REF: rdata_next[7:0] = ref_reg;
			atps_pkg::IDX_CLK: rdata_next[7:0] = clk_reg;
			atps_pkg::IDX_STATUS: begin
				rdata_next[atps_pkg::STAT_BUSY_BIT] = seq_busy;
				rdata_next[atps_pkg::STAT_CCLK_BIT] = div_clk;
			end
			default: rresp_next = atps_pkg::RESP_SLVERR;
		endcase
	end

	// one read at a time, answered on the same edge that takes the address
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= atps_pkg::RESP_OKAY;
		end else begin
			if (s_axi_arvalid && arready_reg) begin
				arready_reg <= 1'b0;
				rvalid_reg <= 1'b1;
				rdata_reg <= rdata_next;
				rresp_reg <= rresp_next;
			end else if (rvalid_reg && s_axi_rready) begin
				rvalid_reg <= 1'b0;
			end else if (!rvalid_reg) begin
				arready_reg <= 1'b1;
			end
		end
	end

	// ****************************************
	// analog configuration outputs
	// ****************************************

	// fields are re-registered so the core sees flop outputs only
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			analog_cfg_reg <= '0;
		end else begin
			analog_cfg_reg.ref_source_sel <= ref_reg[atps_pkg::REF_SRC_BIT];
			analog_cfg_reg.ref_level_sel <= ref_reg[atps_pkg::REF_LVL_BIT];
			analog_cfg_reg.internal_ref_channel <= ref_reg[atps_pkg::REF_CH_LSB +: 2];
			analog_cfg_reg.offset_cancel_open <= ref_reg[atps_pkg::OFS_MODE_BIT];
			analog_cfg_reg.comp_bias_hi <= timing_reg[atps_pkg::COMP_BIAS_BIT];
			analog_cfg_reg.amp_bias_hi <= timing_reg[atps_pkg::AMP_BIAS_BIT];
			analog_cfg_reg.filter_en <= clk_reg[atps_pkg::FILTER_BIT];
		end
	end

	// timing fields for the sequencer and divider
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			timing_cfg_reg <= '0;
		end else begin
			timing_cfg_reg.post_sample_wait_count <= timing_reg[atps_pkg::WNUM_LSB +: 5];
			timing_cfg_reg.sample_compare_gap <= clk_reg[atps_pkg::GAP_BIT];
			timing_cfg_reg.sample_delay_sel <= clk_reg[atps_pkg::SDEL_LSB +: 2];
			timing_cfg_reg.conv_clock_div_sel <= clk_reg[atps_pkg::CKDIV_LSB +: 2];
		end
	end

	// ****************************************
	// pin multiplexer control
	// ****************************************

	// one flop pair per channel, lsb of each byte is its lowest channel
	for (genvar n = 0; n < PIN_COUNT; n++) begin : g_pin
		always_ff @(posedge sys_clk) begin
			if (!resetn) begin
				pin_en_reg[n] <= 1'b0;
				pin_in_reg[n] <= 1'b0;
			end else begin
				pin_en_reg[n] <= pin_sel_reg[n / 8][n % 8];
				pin_in_reg[n] <= pin_sel_reg[n / 8][n % 8];
			end
		end
	end

	// ****************************************
	// conversion clock and timing
	// ****************************************

	atps_clk_div u_clk_div (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.pll_tick(pll_tick),
		.div_sel(timing_cfg_reg.conv_clock_div_sel),
		.conv_clk(div_clk),
		.conv_tick(div_tick)
	);

	atps_seq u_seq (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.conv_tick(div_tick),
		.sample_done(sample_done),
		.timing(timing_cfg_reg),
		.compare_start(seq_start),
		.busy(seq_busy)
	);

	// ****************************************
	// output assignments
	// ****************************************

	// all straight from flops
	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign analog_cfg = analog_cfg_reg;
	assign timing_cfg = timing_cfg_reg;
	assign conv_clk = div_clk;
	assign conv_tick = div_tick;
	assign compare_start = seq_start;
	assign pin_analog_en = pin_en_reg;
	assign pin_force_input = pin_in_reg;

endmodule

// file: testbench/atps_top_sva.sv
// assertion checker for the converter config block ports
`timescale 1ns/1ps
module atps_top_sva #(
	parameter int PIN_COUNT = 24
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire atps_pkg::atps_analog_cfg_s analog_cfg,
	input wire atps_pkg::atps_timing_s timing_cfg,
	input wire logic conv_tick,
	input wire logic compare_start,
	input wire logic [PIN_COUNT-1:0] pin_analog_en,
	input wire logic [PIN_COUNT-1:0] pin_force_input
);
	// ****************************************
	// properties
	// ****************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	sequence s_ar_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence s_rd_answer;
		s_axi_rvalid && !s_axi_arready;
	endsequence
	a_pin_force_input: assert property (pin_force_input == pin_analog_en)
		else $error("pin direction differs from analog select");
	// config follows writes
	// the delay on resetn skips the copy of reset values just after release
	// outputs move one edge after the commit, when the answer may already be taken
	a_cfg_after_write: assert property ($past(resetn, 2) && ($changed(analog_cfg)
		|| $changed(timing_cfg) || $changed(pin_analog_en)) |-> $past(s_axi_bvalid))
		else $error("config output moved without a write");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped early");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped early");
	a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer repeated after handshake");
	a_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer repeated after handshake");
	a_aw_single: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("write address accepted twice");
	a_read_answer: assert property (s_ar_taken |=> s_rd_answer)
		else $error("read not answered in one cycle");
	a_tick_pulse: assert property (conv_tick |=> (!conv_tick) [*8])
		else $error("conversion tick too close");
	a_compare_tick: assert property (compare_start |-> $past(conv_tick))
		else $error("compare start without a conversion tick");
endmodule

bind atps_top atps_top_sva #(.PIN_COUNT(PIN_COUNT)) u_sva (.sys_clk(sys_clk), .resetn(resetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .analog_cfg(analog_cfg), .timing_cfg(timing_cfg),
	.conv_tick(conv_tick), .compare_start(compare_start), .pin_analog_en(pin_analog_en),
	.pin_force_input(pin_force_input));

// file: testbench/atps_core_model.sv
// converter core stand-in: pll tick source and end-of-sampling pulses
`timescale 1ns/1ps
module atps_core_model (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic start,
	output logic pll_tick,
	output logic sample_done
);
	// as wide as 100 + 48 needs, so the sum cannot wrap
	logic [7:0] acc_reg;
	// pll tick source
	// 48 of every 100 cycles tick, spread evenly as a 48 mhz edge would be
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			acc_reg <= 8'h00;
			pll_tick <= 1'b0;
		end else if (acc_reg + 8'h30 >= 8'h64) begin
			acc_reg <= acc_reg + 8'h30 - 8'h64;
			pll_tick <= 1'b1;
		end else begin
			acc_reg <= acc_reg + 8'h30;
			pll_tick <= 1'b0;
		end
	end
	// end of sampling, one cycle per request
	always_ff @(posedge sys_clk) begin
		sample_done <= resetn & start;
	end
endmodule

// file: testbench/test_adc_timing_and_pin_select.sv
// self-checking bench for the converter config block
`timescale 1ns/1ps
module test_adc_timing_and_pin_select;
	logic sys_clk = 1'b0, resetn = 1'b0, start = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [15:0] awaddr = 16'h0000, araddr = 16'h0000;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0] wstrb = 4'h0;
	logic awready, wready, bvalid, arready, rvalid, pll_tick, sample_done;
	logic conv_clk, conv_tick, compare_start;
	logic [1:0] bresp, rresp;
	logic [23:0] pin_en, pin_in;
	atps_pkg::atps_analog_cfg_s analog_cfg;
	atps_pkg::atps_timing_s timing_cfg;
	int num_errors = 0, cmp_count = 0;
	logic [7:0] sh [6];
	logic [13:0] idx_tab [6] = '{atps_pkg::IDX_PIN_LOW, atps_pkg::IDX_PIN_MID,
		atps_pkg::IDX_PIN_HIGH, atps_pkg::IDX_TIMING, atps_pkg::IDX_REF, atps_pkg::IDX_CLK};
	logic [7:0] mask_tab [6] = '{8'hff, 8'hff, 8'hff, atps_pkg::MASK_TIMING,
		atps_pkg::MASK_REF, atps_pkg::MASK_CLK};
	logic [7:0] rst_tab [6] = '{8'h00, 8'h00, 8'h00, 8'h7f, 8'h00, 8'h00};

	atps_top i_dut (.sys_clk(sys_clk), .resetn(resetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .pll_tick(pll_tick), .sample_done(sample_done),
		.analog_cfg(analog_cfg), .timing_cfg(timing_cfg), .conv_clk(conv_clk),
		.conv_tick(conv_tick), .compare_start(compare_start), .pin_analog_en(pin_en),
		.pin_force_input(pin_in));
	atps_core_model i_core (.sys_clk(sys_clk), .resetn(resetn), .start(start),
		.pll_tick(pll_tick), .sample_done(sample_done));

	// ****************************************
	// helpers
	// ****************************************
	// 100 mhz system clock
	initial forever #5 sys_clk = ~sys_clk;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t ns: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// one bus transfer; ready for the answer stands from the request until it comes
	task automatic xfer(input logic wr, input logic [13:0] idx, input logic [7:0] d,
		input logic strb, output logic [31:0] rd, output logic [1:0] resp);
		int n;
		logic done;
		n = 0;
		done = 1'b0;
		rd = 32'h0;
		resp = 2'h3;
		@(posedge sys_clk);
		awaddr <= {idx, 2'h0};
		araddr <= {idx, 2'h0};
		wdata <= {24'h0, d};
		wstrb <= {3'h0, strb};
		awvalid <= wr;
		wvalid <= wr;
		arvalid <= !wr;
		bready <= wr;
		rready <= !wr;
		while (!done && n < 100) begin
			@(posedge sys_clk);
			n++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (arvalid && arready) arvalid <= 1'b0;
			if ((bvalid && bready) || (rvalid && rready)) begin
				done = 1'b1;
				resp = wr ? bresp : rresp;
				rd = rdata;
				bready <= 1'b0;
				rready <= 1'b0;
			end
		end
		if (!done) num_errors++;
	endtask

	task automatic wr_reg(input int k, input logic [7:0] d, input logic strb);
		logic [31:0] rd;
		logic [1:0] resp;
		xfer(1'b1, idx_tab[k], d, strb, rd, resp);
		check(32'(resp), 32'(atps_pkg::RESP_OKAY));
		if (strb) sh[k] = d & mask_tab[k];
	endtask

	task automatic rd_reg(input logic [13:0] idx, input logic [7:0] exp, input logic [1:0] er);
		logic [31:0] rd;
		logic [1:0] resp;
		xfer(1'b0, idx, 8'h00, 1'b0, rd, resp);
		check(rd, {24'h0, exp});
		check(32'(resp), 32'(er));
	endtask

	function automatic logic [7:0] exp_analog();
		return {sh[5][7], sh[3][0], sh[3][1], sh[4][4:0]};
	endfunction

	function automatic logic [9:0] exp_timing();
		return {sh[3][6:2], sh[5][6], sh[5][5:4], sh[5][1:0]};
	endfunction

	task automatic check_outputs();
		check({8'h0, pin_en}, {8'h0, sh[2], sh[1], sh[0]});
		check({8'h0, pin_in}, {8'h0, sh[2], sh[1], sh[0]});
		check(32'(analog_cfg), 32'(exp_analog()));
		check(32'(timing_cfg), 32'(exp_timing()));
	endtask

	// pll ticks per conversion clock period, from the listed output rates
	function automatic int div_ticks(input logic [1:0] c);
		case (c)
			2'h0: return atps_pkg::PLL_HZ / atps_pkg::CONV_HZ_0;
			2'h1: return atps_pkg::PLL_HZ / atps_pkg::CONV_HZ_1;
			2'h2: return atps_pkg::PLL_HZ / atps_pkg::CONV_HZ_2;
			default: return atps_pkg::PLL_HZ / atps_pkg::CONV_HZ_3;
		endcase
	endfunction

	function automatic int exp_n();
		int del [4] = '{0, 2, 4, 8};
		return 3 + int'(sh[3][6:2]) + del[sh[5][5:4]] + int'(sh[5][6]);
	endfunction

	// divider period, then one conversion with a stray second start while busy
	task automatic run_conversion();
		int ticks, plls;
		logic sent;
		ticks = 0;
		plls = 0;
		sent = 1'b0;
		repeat (2) do @(posedge sys_clk); while (!conv_tick);
		do begin
			@(posedge sys_clk);
			plls += int'(pll_tick);
		end while (!conv_tick);
		check(32'(plls), 32'(div_ticks(sh[5][1:0])));
		check(32'(conv_clk), 32'h1);
		// status: idle sequencer, conversion clock still high for a half period
		rd_reg(atps_pkg::IDX_STATUS, 8'h02, atps_pkg::RESP_OKAY);
		start <= 1'b1;
		@(posedge sys_clk);
		start <= 1'b0;
		do @(posedge sys_clk); while (!sample_done);
		while (ticks < 2000) begin
			@(posedge sys_clk);
			if (compare_start) break;
			ticks += int'(conv_tick);
			if (ticks == 2 && !sent) begin
				start <= 1'b1;
				sent = 1'b1;
			end else start <= 1'b0;
		end
		check(32'(ticks), 32'(exp_n()));
	endtask

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		logic [31:0] r, rd;
		logic [1:0] resp;
		void'($urandom(67511));
		repeat (4) @(posedge sys_clk);
		resetn <= 1'b1;
		for (int k = 0; k < 6; k++) sh[k] = rst_tab[k];
		for (int k = 0; k < 6; k++) rd_reg(idx_tab[k], sh[k], atps_pkg::RESP_OKAY);
		check_outputs();
		rd_reg(14'h2050, 8'h00, atps_pkg::RESP_SLVERR);
		xfer(1'b1, 14'h2050, 8'h5a, 1'b1, rd, resp);
		check(32'(resp), 32'(atps_pkg::RESP_SLVERR));
		xfer(1'b1, atps_pkg::IDX_STATUS, 8'hff, 1'b1, rd, resp);
		check(32'(resp), 32'(atps_pkg::RESP_OKAY));
		for (int i = 0; i < 16; i++) begin
			r = $urandom;
			wr_reg(i % 3, r[7:0], r[8] | (i < 3));
			wr_reg(3, {r[9], (i == 0) ? 5'd2 : (i == 1) ? 5'd31 : 5'($urandom_range(2, 31)),
				r[11:10]}, 1'b1);
			wr_reg(4, {r[19:15], 2'(i), r[14]}, 1'b1);
			wr_reg(5, {r[22:21], ~2'(i), r[24:23], 2'(i)}, 1'b1);
			for (int k = 0; k < 6; k++) rd_reg(idx_tab[k], sh[k], atps_pkg::RESP_OKAY);
			check_outputs();
			if (i < 4) run_conversion();
		end
		resetn <= 1'b0;
		repeat (2) @(posedge sys_clk);
		resetn <= 1'b1;
		for (int k = 0; k < 6; k++) sh[k] = rst_tab[k];
		for (int k = 3; k < 6; k++) rd_reg(idx_tab[k], sh[k], atps_pkg::RESP_OKAY);
		check_outputs();
		end_of_test();
	end

	// watchdog at a few times the longest expected run, inside the cycle budget
	initial begin
		#500_000;
		num_errors++;
		end_of_test();
	end
endmodule
